// ---- logic/rcpr_map.vh ----
// register offsets, field positions and reset values of the regulator control bank
`ifndef RCPR_MAP_VH
`define RCPR_MAP_VH
`define RCPR_ADDR_RAIL_D     8'h6f
`define RCPR_ADDR_LREG_C     8'h70
`define RCPR_ADDR_LREG_E     8'h71
`define RCPR_ADDR_PAGE       8'h7f
`define RCPR_EXT_BASE        8'h80
`define RCPR_PAGE_FUNC       4'h0
`define RCPR_PAGE_EXT1       4'h1
`define RCPR_PAGE_EXT2       4'h2
`define RCPR_BIT_OMODE       7
`define RCPR_BIT_LPWR        6
`define RCPR_BIT_STBY        5
`define RCPR_BIT_EN          4
`define RCPR_RST_PAGE        4'h0
`define RCPR_RST_UPPER       3'h0
`define RCPR_BUILTIN_RAIL_D  3'h4
`define RCPR_BUILTIN_LREG    5'h10
`endif

// ---- logic/rcpr_ctl_reg.v ----
// one regulator control register with fuse-loaded enable and voltage code
`timescale 1ns/100ps
`default_nettype none
`include "rcpr_map.vh"
module rcpr_ctl_reg #(
    parameter CODE_W = 4
) (
    input  wire              mclk,
    input  wire              rst,
    input  wire              por_rst,
    input  wire              digital_rst,
    input  wire              load,
    input  wire [CODE_W:0]   load_value,
    input  wire              wr,
    input  wire [7:0]        wdata,
    output wire [7:0]        rdata,
    output reg               off_event_mode,
    output reg               low_power_allow,
    output reg               standby_off,
    output reg               enable,
    output reg  [CODE_W-1:0] voltage_code
);
    // upper control bits: reset by por or turn-off request
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            off_event_mode  <= 1'b0;
            low_power_allow <= 1'b0;
            standby_off     <= 1'b0;
        end else if (por_rst) begin
            off_event_mode  <= 1'b0;
            low_power_allow <= 1'b0;
            standby_off     <= 1'b0;
        end else if (wr) begin
            off_event_mode  <= wdata[`RCPR_BIT_OMODE];
            low_power_allow <= wdata[`RCPR_BIT_LPWR];
            standby_off     <= wdata[`RCPR_BIT_STBY];
        end
    end
    // enable and code: loaded from fuses, writable after load
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            enable       <= 1'b0;
            voltage_code <= {CODE_W{1'b0}};
        end else if (load) begin
            enable       <= load_value[CODE_W];
            voltage_code <= load_value[CODE_W-1:0];
        end else if (wr && !digital_rst) begin
            enable       <= wdata[`RCPR_BIT_EN];
            voltage_code <= wdata[CODE_W-1:0];
        end
    end
    assign rdata[7:4]        = {off_event_mode, low_power_allow, standby_off, enable};
    assign rdata[CODE_W-1:0] = voltage_code;
    // unused code bits read zero; a zero-width pad would be illegal for the four-bit code
    generate
        if (CODE_W < 4) begin : g_pad
            assign rdata[3:CODE_W] = {(4-CODE_W){1'b0}};
        end
    endgenerate
endmodule
`default_nettype wire

// ---- logic/rcpr_bank.v ----
// paged regulator control register bank
// Functional notes
// RULE1: bit 7 picks off (0) or sleep (1) on button turn-off event.
// RULE2: bit 6 allows low-power mode when outside conditions hold.
// RULE3: bit 5 set turns regulator off during standby.
// RULE4: bit 4 enables the regulator output.
// RULE5: fixed-rail code sits in bits 1:0.
// RULE6: other two regulators use four-bit code in bits 3:0.
// RULE7: fourth regulator has the same off-event mode bit.
// RULE8: enable and code reset values come from fuse configuration.
// RULE9: page field 0 functional, 1 extended one, 2 extended two.
// RULE10: eight-bit address and data, thirty-two pages, few reachable. Code has a four-bit page field, sixteen pages.
// RULE11: 0..0x7f shared on all pages, 0x80..0xff page specific.
// RULE12: host writes 1 or 2 to page register 0x7f first.
// RULE13: functional registers stay reachable under any selected page.
// RULE14: unimplemented addresses read zero and ignore writes.
// RULE15: access types read-only, read-write, write-one-to-clear supported. Code has read-write registers only.
// RULE16: each bit belongs to one of six reset groups.
// RULE17: fuse-default bits load at start-up, builtin when strap set.
// RULE18: per-regulator controls go out, condition signals come in.
`timescale 1ns/100ps
`default_nettype none
`include "rcpr_map.vh"
module rcpr_bank (
    input  wire       mclk,
    input  wire       rst,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    input  wire       core_domain_power_on_reset_n,
    input  wire       logic_reset_n,
    input  wire       processor_power_on_reset_n,
    input  wire       host_reset_n,
    input  wire       turn_off_request_n,
    input  wire       power_button_event,
    input  wire       sleep_cycle_reset,
    input  wire       fuse_supply_strap,
    input  wire       fuse_valid,
    input  wire [2:0] fuse_rail_d,
    input  wire [4:0] fuse_linear_reg_c,
    input  wire [4:0] fuse_linear_reg_e,
    input  wire       low_power_request,
    input  wire       standby_request,
    output wire       rail_d_on,
    output wire       rail_d_sleep,
    output wire       rail_d_low_power,
    output wire [1:0] rail_d_voltage_code,
    output wire       linear_reg_c_on,
    output wire       linear_reg_c_sleep,
    output wire       linear_reg_c_low_power,
    output wire [3:0] linear_reg_c_voltage_code,
    output wire       linear_reg_e_on,
    output wire       linear_reg_e_sleep,
    output wire       linear_reg_e_low_power,
    output wire [3:0] linear_reg_e_voltage_code,
    output reg  [3:0] page_select,
    output wire       page_extended
);
    // synchronisers for outside inputs
    reg  [10:0] sync_a;
    reg  [10:0] sync_b;
    wire [10:0] raw_in = {core_domain_power_on_reset_n, logic_reset_n, processor_power_on_reset_n,
                          host_reset_n, turn_off_request_n, power_button_event, sleep_cycle_reset,
                          fuse_supply_strap, fuse_valid, low_power_request, standby_request};
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync_a <= 11'h7c0;
            sync_b <= 11'h7c0;
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
        end
    end
    wire core_por_n  = sync_b[10];
    wire dig_rst_n   = sync_b[9];
    wire proc_por_n  = sync_b[8];
    wire host_rst_n  = sync_b[7];
    wire off_req_n   = sync_b[6];
    wire button_evt  = sync_b[5];
    wire sleep_rst   = sync_b[4];
    wire strap_sync  = sync_b[3];
    wire fuse_ok     = sync_b[2];
    wire lp_cond     = sync_b[1];
    wire stby_cond   = sync_b[0];

    // reset group terms
    wire grp_sc_core   = sleep_rst | ~core_por_n;         // RULE16
    wire grp_por_off   = ~proc_por_n | ~off_req_n;        // RULE16
    wire grp_digital   = ~dig_rst_n;                      // RULE16
    wire grp_host      = ~proc_por_n | ~host_rst_n;       // RULE16
    wire grp_core      = ~core_por_n;                     // RULE16

    // fuse load: on start-up, button event or core por release
    reg  loaded;
    reg  load_pulse;
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            loaded     <= 1'b0;
            load_pulse <= 1'b0;
        end else begin
            load_pulse <= 1'b0;
            if (grp_core || button_evt) begin
                loaded <= 1'b0;                           // RULE16
            end else if (!loaded && (fuse_ok || strap_sync)) begin
                loaded     <= 1'b1;
                load_pulse <= 1'b1;                       // RULE17
            end
        end
    end
    wire [2:0] ld_rail_d = strap_sync ? `RCPR_BUILTIN_RAIL_D : fuse_rail_d;      // RULE17
    wire [4:0] ld_lreg_c = strap_sync ? `RCPR_BUILTIN_LREG : fuse_linear_reg_c;  // RULE17
    wire [4:0] ld_lreg_e = strap_sync ? `RCPR_BUILTIN_LREG : fuse_linear_reg_e;  // RULE17

    // decode
    wire is_func  = (reg_addr < `RCPR_EXT_BASE);                         // RULE11
    wire hit_d    = is_func && (reg_addr == `RCPR_ADDR_RAIL_D);          // RULE13
    wire hit_c    = is_func && (reg_addr == `RCPR_ADDR_LREG_C);
    wire hit_e    = is_func && (reg_addr == `RCPR_ADDR_LREG_E);
    wire hit_page = is_func && (reg_addr == `RCPR_ADDR_PAGE);
    wire wr_ok    = reg_wr && loaded;                                    // RULE17

    wire [7:0] rd_d;
    wire [7:0] rd_c;
    wire [7:0] rd_e;
    wire       d_omode, d_lpwr, d_stby, d_en;
    wire       c_omode, c_lpwr, c_stby, c_en;
    wire       e_omode, e_lpwr, e_stby, e_en;

    rcpr_ctl_reg #(.CODE_W(2)) u_rail_d (                                // RULE5
        .mclk            (mclk),
        .rst             (rst),
        .por_rst         (grp_por_off),
        .digital_rst     (grp_digital),
        .load            (load_pulse),                                   // RULE8
        .load_value      (ld_rail_d),
        .wr              (wr_ok && hit_d),
        .wdata           (reg_wdata),
        .rdata           (rd_d),
        .off_event_mode  (d_omode),                                      // RULE1
        .low_power_allow (d_lpwr),                                       // RULE2
        .standby_off     (d_stby),                                       // RULE3
        .enable          (d_en),                                         // RULE4
        .voltage_code    (rail_d_voltage_code)
    );
    rcpr_ctl_reg #(.CODE_W(4)) u_lreg_c (                                // RULE6
        .mclk            (mclk),
        .rst             (rst),
        .por_rst         (grp_por_off),
        .digital_rst     (grp_digital),
        .load            (load_pulse),                                   // RULE8
        .load_value      (ld_lreg_c),
        .wr              (wr_ok && hit_c),
        .wdata           (reg_wdata),
        .rdata           (rd_c),
        .off_event_mode  (c_omode),
        .low_power_allow (c_lpwr),
        .standby_off     (c_stby),
        .enable          (c_en),
        .voltage_code    (linear_reg_c_voltage_code)
    );
    rcpr_ctl_reg #(.CODE_W(4)) u_lreg_e (                                // RULE6
        .mclk            (mclk),
        .rst             (rst),
        .por_rst         (grp_por_off),
        .digital_rst     (grp_digital),
        .load            (load_pulse),                                   // RULE8
        .load_value      (ld_lreg_e),
        .wr              (wr_ok && hit_e),
        .wdata           (reg_wdata),
        .rdata           (rd_e),
        .off_event_mode  (e_omode),                                      // RULE7
        .low_power_allow (e_lpwr),
        .standby_off     (e_stby),
        .enable          (e_en),
        .voltage_code    (linear_reg_e_voltage_code)
    );

    // page register, reset with host reset group
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            page_select <= `RCPR_RST_PAGE;
        end else if (grp_host) begin
            page_select <= `RCPR_RST_PAGE;                               // RULE16
        end else if (reg_wr && hit_page) begin
            page_select <= reg_wdata[3:0];                               // RULE12
        end
    end
    // only functional and extended pages one and two are reachable
    assign page_extended = (page_select == `RCPR_PAGE_EXT1) ||
                           (page_select == `RCPR_PAGE_EXT2);             // RULE9 RULE10

    // read mux, extended space and unused addresses read zero
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (hit_d)
                reg_rdata <= rd_d;
            else if (hit_c)
                reg_rdata <= rd_c;
            else if (hit_e)
                reg_rdata <= rd_e;
            else if (hit_page)
                reg_rdata <= {4'h0, page_select};
            else
                reg_rdata <= 8'h00;                                      // RULE14 RULE15
        end
    end

    // regulator control outputs; sleep-cycle group gates sleep entry
    assign rail_d_on        = d_en & ~(stby_cond & d_stby);              // RULE18 RULE3
    assign rail_d_sleep     = d_omode & ~grp_sc_core;                    // RULE1
    assign rail_d_low_power = d_lpwr & lp_cond;                          // RULE2
    assign linear_reg_c_on        = c_en & ~(stby_cond & c_stby);        // RULE3 RULE4
    assign linear_reg_c_sleep     = c_omode & ~grp_sc_core;
    assign linear_reg_c_low_power = c_lpwr & lp_cond;
    assign linear_reg_e_on        = e_en & ~(stby_cond & e_stby);
    assign linear_reg_e_sleep     = e_omode & ~grp_sc_core;              // RULE7
    assign linear_reg_e_low_power = e_lpwr & lp_cond;
endmodule
`default_nettype wire

// ---- testbench/rcpr_bank_assertions.sv ----
// assertions for the paged regulator control bank
`timescale 1ns/100ps
`default_nettype none
module rcpr_bank_chk (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] rail_d_voltage_code,
    input wire logic [3:0] linear_reg_c_voltage_code,
    input wire logic [3:0] linear_reg_e_voltage_code,
    input wire logic [3:0] page_select,
    input wire logic       page_extended
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire mapped = reg_addr inside {8'h6f, 8'h70, 8'h71, 8'h7f};
    page_flag_a: assert property (page_extended == (page_select inside {4'h1, 4'h2}))
        else $error("page flag wrong");
    page_write_a: assert property (reg_wr && reg_addr == 8'h7f |=> {4'h0, page_select} == ($past(reg_wdata) & 8'h0f))
        else $error("page write lost");
    c_code_a: assert property (reg_wr && reg_addr == 8'h70 |=> {4'h0, linear_reg_c_voltage_code} == ($past(reg_wdata) & 8'h0f))
        else $error("c code write lost");
    d_code_a: assert property (reg_wr && reg_addr == 8'h6f |=> {6'h0, rail_d_voltage_code} == ($past(reg_wdata) & 8'h03))
        else $error("d code write lost");
    unmapped_read_a: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    page_read_a: assert property (reg_rd && reg_addr == 8'h7f |=> reg_rdata == {4'h0, $past(page_select)})
        else $error("page read wrong");
    read_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");
    e_read_a: assert property (reg_rd && reg_addr == 8'h71 |=> reg_rdata[3:0] == $past(linear_reg_e_voltage_code))
        else $error("e read wrong");
    cover property (reg_rd && reg_addr[7] && page_extended);
    cover property (reg_wr && reg_addr == 8'h70);
    cover property (page_select == 4'h2 ##1 page_select == 4'h0);
endmodule
bind rcpr_bank rcpr_bank_chk chk_u (.mclk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .rail_d_voltage_code, .linear_reg_c_voltage_code, .linear_reg_e_voltage_code, .page_select, .page_extended);
`default_nettype wire

// ---- testbench/rcpr_host.sv ----
// host model driving the register strobes
`timescale 1ns/100ps
`default_nettype none
module rcpr_host (
    input  wire logic       mclk,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // one access per cycle, launched just after the edge
    task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1;
        reg_wr = w;
        reg_rd = r;
        reg_addr = a;
        reg_wdata = d;
    endtask
    // released bus shows the inverse of its last value
    task automatic idle();
        op(1'b0, 1'b0, ~reg_addr, ~reg_wdata);
    endtask
endmodule
`default_nettype wire

// ---- testbench/rcpr_bank_test.sv ----
// self-checking bench for the paged regulator control bank
`timescale 1ns/100ps
`default_nettype none
module rcpr_bank_test;
    logic       mclk, rst, wr, rd, strap, fvalid, hrst_n, btn, lpr, sbr, rd_d, pe;
    logic [7:0] addr, wdata, rdata;
    logic [7:0] v [3];
    logic [7:0] exp_q [$];
    logic [2:0] fd;
    logic [4:0] fc, fe;
    logic [1:0] dc;
    logic [3:0] cc, ec, pg;
    integer     err_count = 0, checks_done = 0, seed = 61192;
    rcpr_host host_u (.mclk, .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata));
    rcpr_bank dut_u (.mclk, .rst, .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
        .core_domain_power_on_reset_n(1'b1), .logic_reset_n(1'b1), .processor_power_on_reset_n(1'b1),
        .host_reset_n(hrst_n), .turn_off_request_n(1'b1), .power_button_event(btn), .sleep_cycle_reset(1'b0),
        .fuse_supply_strap(strap), .fuse_valid(fvalid), .fuse_rail_d(fd), .fuse_linear_reg_c(fc),
        .fuse_linear_reg_e(fe), .low_power_request(lpr), .standby_request(sbr), .rail_d_on(), .rail_d_sleep(),
        .rail_d_low_power(), .rail_d_voltage_code(dc), .linear_reg_c_on(), .linear_reg_c_sleep(),
        .linear_reg_c_low_power(), .linear_reg_c_voltage_code(cc), .linear_reg_e_on(), .linear_reg_e_sleep(),
        .linear_reg_e_low_power(), .linear_reg_e_voltage_code(ec), .page_select(pg), .page_extended(pe));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdx(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_u.op(1'b0, 1'b1, a, 8'h00);
    endtask
    task automatic hold(input int n);
        host_u.idle();
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wrap_up();
        $display("mismatches %0d comparisons %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // condition inputs wander at random
    always @(posedge mclk) begin
        #1;
        lpr <= $random(seed);
        sbr <= $random(seed);
    end
    always @(posedge mclk) rd_d <= rd;
    always @(negedge mclk) begin
        if (rd_d === 1'b1 && exp_q.size() > 0) begin
            cmp("rdata", exp_q.pop_front(), rdata);
        end
    end
    initial begin
        #(400 * 100);
        err_count++;
        wrap_up();
    end
    initial begin
        {rst, strap, fvalid, hrst_n, btn, lpr, sbr, rd_d} = 8'b1011_0000;
        {fd, fc, fe} = 13'($random(seed));
        repeat (2) @(posedge mclk);
        #1 rst = 1'b0;
        hold(10);
        cmp("d_code", {6'h0, fd[1:0]}, {6'h0, dc});
        rdx(8'h6f, {3'h0, fd[2], 2'h0, fd[1:0]});
        rdx(8'h70, {3'h0, fc});
        rdx(8'h71, {3'h0, fe});
        rdx(8'h7f, 8'h00);
        for (int i = 0; i < 3; i++) begin
            v[i] = 8'($random(seed));
            host_u.op(1'b1, 1'b0, 8'h6f + i[7:0], v[i]);
        end
        rdx(8'h6f, v[0] & 8'hf3);
        rdx(8'h70, v[1]);
        rdx(8'h71, v[2]);
        hold(0);
        cmp("c_code", {4'h0, v[1][3:0]}, {4'h0, cc});
        cmp("e_code", {4'h0, v[2][3:0]}, {4'h0, ec});
        for (int i = 0; i < 3; i++) begin
            host_u.op(1'b1, 1'b0, 8'h7f, i[7:0]);
            rdx(8'h7f, i[7:0]);
            rdx(8'h70, v[1]);
            rdx(8'h80, 8'h00);
            host_u.op(1'b1, 1'b0, 8'hff, 8'hff);
            rdx(8'hff, 8'h00);
            hold(0);
            cmp("page_ext", {7'h0, i != 0}, {7'h0, pe});
        end
        host_u.op(1'b1, 1'b0, 8'h05, 8'hff);
        rdx(8'h05, 8'h00);
        hold(0);
        hrst_n = 1'b0;
        hold(3);
        hrst_n = 1'b1;
        hold(4);
        cmp("page", 8'h00, {4'h0, pg});
        btn = 1'b1;
        hold(3);
        btn = 1'b0;
        hold(12);
        cmp("c_code", {4'h0, fc[3:0]}, {4'h0, cc});
        rdx(8'h70, {v[1][7:5], fc});
        hold(1);
        {rst, strap, fvalid} = 3'b110;
        hold(2);
        rst = 1'b0;
        hold(10);
        rdx(8'h6f, 8'h10);
        rdx(8'h70, 8'h10);
        rdx(8'h71, 8'h10);
        hold(3);
        wrap_up();
    end
endmodule
`default_nettype wire
